// ===== include/sbrg_pkg.sv
// package for the serial baud rate generator: register map, fields, reset values
//
// What this block does
// - async low speed: bit rate is oscillator over 64 times divisor plus one
// - async high speed: bit rate is oscillator over 16 times divisor plus one
// - sync master: bit clock is oscillator over 4 times divisor plus one
// - writing the divisor reloads the rate timer with the new divisor and clears the prescaler at once
// - async modes: receive pin sampled three times per bit, level chosen by majority
// - divisor is unsigned 0..255, 0 fastest and 255 slowest
// - divisor reads zero after every reset
// - divisor sets period of a free-running 8-bit timer for all modes
// - sync mode ignores the high speed select
package sbrg_pkg;
  localparam logic [7:0] SBRG_OFF_RCSTAT   = 8'h18;
  localparam logic [7:0] SBRG_OFF_TXSTAT   = 8'h98;
  localparam logic [7:0] SBRG_OFF_DIVISOR  = 8'h99;
  localparam logic [7:0] SBRG_OFF_STATUS   = 8'hA0;
  localparam logic [7:0] SBRG_RST_RCSTAT   = 8'h00;
  localparam logic [7:0] SBRG_RST_TXSTAT   = 8'h02;
  localparam logic [7:0] SBRG_RST_DIVISOR  = 8'h00;
  localparam int         SBRG_BIT_SYNC     = 4;
  localparam int         SBRG_BIT_HSEL     = 2;
  localparam int         SBRG_BIT_ENABLE   = 7;
  localparam logic [7:0] SBRG_TXSTAT_MASK  = 8'hF7;
  localparam logic [5:0] SBRG_PRE_LOW      = 6'h3F;
  localparam logic [5:0] SBRG_PRE_HIGH     = 6'h0F;
  localparam logic [5:0] SBRG_PRE_SYNC     = 6'h03;
  localparam logic [5:0] SBRG_SAMPLE_A     = 6'h06;
  localparam logic [5:0] SBRG_SAMPLE_B     = 6'h07;
  localparam logic [5:0] SBRG_SAMPLE_C     = 6'h08;
  localparam logic [5:0] SBRG_SAMPLE_A_HS  = 6'h06;
endpackage : sbrg_pkg

// ===== logic/sbrg_majority.sv
// three-sample majority detector for the receive pin
`timescale 1ns/1ps
`default_nettype none
module sbrg_majority
  import sbrg_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sample_en,
  input  wire logic       sample_last,
  input  wire logic       pin,
  output var  logic       level,
  output var  logic       level_valid
);
  logic [1:0] samples;
  logic [1:0] next_samples;
  logic       next_level;
  logic       next_level_valid;

  always_comb begin
    next_samples     = samples;
    next_level       = level;
    next_level_valid = 1'b0;
    if (sample_en && sample_last) begin
      // two of three decide the level
      next_level       = (samples[0] & samples[1]) | (samples[0] & pin) | (samples[1] & pin);
      next_level_valid = 1'b1;
    end else if (sample_en) begin
      next_samples = {samples[0], pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samples     <= 2'h3;
      level       <= 1'b1;
      level_valid <= 1'b0;
    end else begin
      samples     <= next_samples;
      level       <= next_level;
      level_valid <= next_level_valid;
    end
  end
endmodule : sbrg_majority
`default_nettype wire

// ===== logic/sbrg_top.sv
// serial baud rate generator with apb register access and receive majority vote
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sbrg_top
  import sbrg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        receive_data_pin,
  output var  logic        bit_tick,
  output var  logic        sample_tick,
  output var  logic        rx_level,
  output var  logic        rx_level_valid,
  output var  logic        serial_enable
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  receive_status_control;
  logic [7:0]  transmit_status_control;
  logic [7:0]  baud_divisor;
  logic [7:0]  next_rcstat;
  logic [7:0]  next_txstat;
  logic [7:0]  next_divisor;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        div_write;
  logic        access;
  logic [7:0]  word;
  logic [5:0]  prescale;

  assign access = psel && penable && !pready;
  assign word   = paddr[9:2];

  // one wait state: the first access edge loads pready, so the answer stands a single cycle
  always_comb begin
    next_rcstat  = receive_status_control;
    next_txstat  = transmit_status_control;
    next_divisor = baud_divisor;
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    div_write    = 1'b0;
    if (access) begin
      next_pready = 1'b1;
      if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
        next_pslverr = 1'b1;
      end else if (pwrite) begin
        if (word == SBRG_OFF_RCSTAT && pstrb[0]) begin
          next_rcstat = pwdata[7:0];
        end else if (word == SBRG_OFF_TXSTAT && pstrb[0]) begin
          next_txstat = pwdata[7:0] & SBRG_TXSTAT_MASK;
        end else if (word == SBRG_OFF_DIVISOR && pstrb[0]) begin
          next_divisor = pwdata[7:0];
          div_write    = 1'b1;
        end else if (word != SBRG_OFF_RCSTAT && word != SBRG_OFF_TXSTAT &&
                     word != SBRG_OFF_DIVISOR) begin
          next_pslverr = 1'b1;
        end
      end else begin
        unique case (word)
          SBRG_OFF_RCSTAT:  next_prdata = {24'h00_0000, receive_status_control};
          SBRG_OFF_TXSTAT:  next_prdata = {24'h00_0000, transmit_status_control};
          SBRG_OFF_DIVISOR: next_prdata = {24'h00_0000, baud_divisor};
          SBRG_OFF_STATUS:  next_prdata = {26'h000_0000, prescale};
          default:          next_pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_status_control  <= SBRG_RST_RCSTAT;
      transmit_status_control <= SBRG_RST_TXSTAT;
      baud_divisor            <= SBRG_RST_DIVISOR;
      prdata                  <= 32'h0000_0000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
    end else begin
      receive_status_control  <= next_rcstat;
      transmit_status_control <= next_txstat;
      baud_divisor            <= next_divisor;
      prdata                  <= next_prdata;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rate timer and prescaler
  logic [7:0] rate_timer;
  logic [7:0] next_timer;
  logic [5:0] next_prescale;
  logic [5:0] pre_top;
  logic       sync_mode;
  logic       high_speed_select;
  logic       timer_expire;
  logic       next_bit_tick;
  logic       next_sample_tick;
  logic       sample_en;
  logic       sample_last;

  assign sync_mode         = transmit_status_control[SBRG_BIT_SYNC];
  assign high_speed_select = transmit_status_control[SBRG_BIT_HSEL];
  assign timer_expire      = (rate_timer == 8'h00);

  // prescaler top is the divide factor less one: 64, 16 or 4 counts per bit
  always_comb begin
    if (sync_mode) begin
      pre_top = SBRG_PRE_SYNC;
    end else if (high_speed_select) begin
      pre_top = SBRG_PRE_HIGH;
    end else begin
      pre_top = SBRG_PRE_LOW;
    end
  end

  always_comb begin
    next_timer       = rate_timer;
    next_prescale    = prescale;
    next_bit_tick    = 1'b0;
    if (div_write) begin
      // restart at once so the new rate needs no old period to drain
      next_timer    = next_divisor;
      next_prescale = 6'h00;
    end else if (timer_expire) begin
      next_timer = baud_divisor;
      if (prescale >= pre_top) begin
        next_prescale = 6'h00;
        next_bit_tick = 1'b1;
      end else begin
        next_prescale = prescale + 6'h01;
      end
    end else begin
      next_timer = rate_timer - 8'h01;
    end
  end

  // three samples in the middle of the bit; sync mode bypasses the vote
  always_comb begin
    sample_en   = 1'b0;
    sample_last = 1'b0;
    if (!div_write && timer_expire && !sync_mode) begin
      if (high_speed_select) begin
        sample_en   = (prescale == SBRG_SAMPLE_A_HS) || (prescale == SBRG_SAMPLE_B) ||
                      (prescale == SBRG_SAMPLE_C);
      end else begin
        // low speed samples sit four counts apart around the middle of the bit
        sample_en   = (prescale[5:2] == 4'h7) && (prescale[1:0] == 2'h3) ||
                      (prescale[5:2] == 4'h8) && (prescale[1:0] == 2'h3) ||
                      (prescale[5:2] == 4'h9) && (prescale[1:0] == 2'h3);
      end
      sample_last = sample_en && (high_speed_select ? (prescale == SBRG_SAMPLE_C)
                                                    : (prescale[5:2] == 4'h9));
    end
    next_sample_tick = sample_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_timer    <= SBRG_RST_DIVISOR;
      prescale      <= 6'h00;
      bit_tick      <= 1'b0;
      sample_tick   <= 1'b0;
      serial_enable <= 1'b0;
    end else begin
      rate_timer    <= next_timer;
      prescale      <= next_prescale;
      bit_tick      <= next_bit_tick;
      sample_tick   <= next_sample_tick;
      serial_enable <= receive_status_control[SBRG_BIT_ENABLE];
    end
  end

  sbrg_majority u_vote (
    .pclk        (pclk),
    .presetn     (presetn),
    .sample_en   (sample_en),
    .sample_last (sample_last),
    .pin         (receive_data_pin),
    .level       (rx_level),
    .level_valid (rx_level_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  // tick_gap counts cycles since the last clean start of a bit period; a mode change
  // mid-period drops gap_exact, since that period is then only bounded, not exact
  logic [15:0] tick_gap;
  logic [15:0] next_tick_gap;
  logic        gap_exact;
  logic        next_gap_exact;
  logic        cfg_write;
  logic [15:0] div_span;
  logic [15:0] low_period;
  logic [15:0] high_period;
  logic [15:0] sync_period;

  assign cfg_write   = (next_txstat != transmit_status_control);
  assign div_span    = {8'h00, baud_divisor} + 16'h0001;
  assign low_period  = 16'(div_span * ({10'h000, SBRG_PRE_LOW} + 16'h0001));
  assign high_period = 16'(div_span * ({10'h000, SBRG_PRE_HIGH} + 16'h0001));
  assign sync_period = 16'(div_span * ({10'h000, SBRG_PRE_SYNC} + 16'h0001));

  always_comb begin
    next_tick_gap  = tick_gap + 16'h0001;
    next_gap_exact = gap_exact;
    if (div_write) begin
      // a divisor write leaves timer and prescaler as reset does
      next_tick_gap  = 16'h0000;
      next_gap_exact = 1'b1;
    end else if (cfg_write) begin
      next_tick_gap  = 16'h0000;
      next_gap_exact = 1'b0;
    end else if (bit_tick) begin
      next_tick_gap  = 16'h0001;
      next_gap_exact = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap  <= 16'h0000;
      gap_exact <= 1'b1;
    end else begin
      tick_gap  <= next_tick_gap;
      gap_exact <= next_gap_exact;
    end
  end

  chk_low_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_tick && gap_exact && !sync_mode && !high_speed_select) |-> tick_gap == low_period)
    else $error("low speed period wrong");
  chk_high_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_tick && gap_exact && !sync_mode && high_speed_select) |-> tick_gap == high_period)
    else $error("high speed period wrong");
  chk_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    bit_tick |-> tick_gap <= 16'(({8'h00, baud_divisor} + 16'h0001) * ({10'h000, pre_top} + 16'h0001)))
    else $error("bit tick late");
  chk_write_restart: assert property (@(posedge pclk) disable iff (!presetn)
    div_write |=> (prescale == 6'h00 && rate_timer == baud_divisor))
    else $error("divisor write did not restart timer");
  chk_timer_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_expire && !div_write) |=> rate_timer == $past(baud_divisor))
    else $error("timer not reloaded");
  chk_sync_ignores_hs: assert property (@(posedge pclk) disable iff (!presetn)
    (bit_tick && gap_exact && sync_mode) |-> tick_gap == sync_period)
    else $error("sync mode uses high speed");
  chk_prescale_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (next_bit_tick && gap_exact) |-> (timer_expire && prescale == pre_top))
    else $error("tick without prescaler wrap");
  chk_vote_valid: assert property (@(posedge pclk) disable iff (!presetn)
    sample_last |=> rx_level_valid)
    else $error("vote result missing");
  chk_divisor_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && word == SBRG_OFF_DIVISOR && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0)
    |=> prdata[7:0] == $past(baud_divisor) && pready)
    else $error("divisor readback wrong");
  chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");
  chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  chk_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
    bit_tick |=> !bit_tick)
    else $error("bit tick longer than one cycle");
  chk_timer_count: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_expire && !div_write) |=> rate_timer == $past(rate_timer) - 8'h01)
    else $error("rate timer did not count down");
  chk_sync_no_vote: assert property (@(posedge pclk) disable iff (!presetn)
    sync_mode |-> !sample_en)
    else $error("vote sampled in sync mode");
  chk_txstat_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (transmit_status_control & ~SBRG_TXSTAT_MASK) == 8'h00)
    else $error("unused control bit set");
  chk_serial_enable: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> serial_enable == $past(receive_status_control[SBRG_BIT_ENABLE]))
    else $error("serial enable does not follow control bit");

  cov_sync_tick:  cover property (@(posedge pclk) disable iff (!presetn) bit_tick && sync_mode);
  cov_hs_tick:    cover property (@(posedge pclk) disable iff (!presetn) bit_tick && high_speed_select);
  cov_vote:       cover property (@(posedge pclk) disable iff (!presetn) rx_level_valid);
  cov_div_write:  cover property (@(posedge pclk) disable iff (!presetn) div_write);
  cov_low_tick:   cover property (@(posedge pclk) disable iff (!presetn) bit_tick && !sync_mode && !high_speed_select);
endmodule : sbrg_top
`default_nettype wire

// ===== verif/tb_sbrg_top.sv
// self-checking bench for the serial baud rate generator, apb register access and vote outputs
`timescale 1ns/1ps
`default_nettype none
module tb_sbrg_top
  import sbrg_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        receive_data_pin;
  logic        bit_tick;
  logic        sample_tick;
  logic        rx_level;
  logic        rx_level_valid;
  logic        serial_enable;
  int          errors;
  int          check_count;
  logic [31:0] rdat;
  logic        rerr;
  int          tx_tab  [6] = '{8'h00, 8'h04, 8'h14, 8'h10, 8'h04, 8'h00};
  int          div_tab [6] = '{2, 2, 2, 0, 255, 0};
  int          per_tab [6] = '{192, 48, 12, 4, 4096, 64};

  sbrg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_data_pin(receive_data_pin), .bit_tick(bit_tick), .sample_tick(sample_tick),
    .rx_level(rx_level), .rx_level_valid(rx_level_valid), .serial_enable(serial_enable));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // word index goes to paddr[9:2]; the master holds everything until pready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("apb ready", 32'h1, {31'h0, n < 50});
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000, 4'hF);
    chk(nm, exp, rdat);
  endtask : rdc

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hF);
  endtask : wr

  // waits for one tick, then counts cycles and vote samples up to the next
  task automatic per(input int exp, input int samples);
    int n;
    int s;
    n = 0;
    s = 0;
    do @(posedge pclk); while (bit_tick !== 1'b1 && ++n < 20000);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (sample_tick === 1'b1) s++;
    end while (bit_tick !== 1'b1 && n < 20000);
    chk("bit period", exp, n);
    chk("vote samples", samples, s);
  endtask : per

  task automatic vote(input logic lvl);
    int n;
    receive_data_pin <= lvl;
    repeat (2) begin
      n = 0;
      do @(posedge pclk); while (rx_level_valid !== 1'b1 && ++n < 2000);
      chk("vote wait", 32'h1, {31'h0, n < 2000});
    end
    chk("rx level", {31'h0, lvl}, {31'h0, rx_level});
  endtask : vote

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    errors = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    receive_data_pin = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("serial enable", 32'h0, {31'h0, serial_enable});
    rdc("rcstat reset", SBRG_OFF_RCSTAT, 32'h0000_0000);
    rdc("txstat reset", SBRG_OFF_TXSTAT, 32'h0000_0002);
    rdc("divisor reset", SBRG_OFF_DIVISOR, 32'h0000_0000);
    apb(1'b0, 8'h01, 32'h0, 4'hF);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    $display("test reset and map done");
    wr(SBRG_OFF_RCSTAT, 32'h0000_0080);
    @(posedge pclk);
    chk("serial enable", 32'h1, {31'h0, serial_enable});
    wr(SBRG_OFF_DIVISOR, 32'h0000_00FF);
    rdc("divisor max", SBRG_OFF_DIVISOR, 32'h0000_00FF);
    apb(1'b1, SBRG_OFF_DIVISOR, 32'h0000_0011, 4'h0);
    rdc("divisor no strobe", SBRG_OFF_DIVISOR, 32'h0000_00FF);
    $display("test divisor access done");
    for (int i = 0; i < 6; i++) begin
      wr(SBRG_OFF_TXSTAT, tx_tab[i]);
      wr(SBRG_OFF_DIVISOR, div_tab[i]);
      per(per_tab[i], (tx_tab[i] & 8'h10) ? 0 : 3);
    end
    $display("test bit periods done");
    wr(SBRG_OFF_TXSTAT, 32'h0000_0000);
    wr(SBRG_OFF_DIVISOR, 32'h0000_00FF);
    repeat (100) @(posedge pclk);
    wr(SBRG_OFF_DIVISOR, 32'h0000_0001);
    n = 0;
    do @(posedge pclk); while (bit_tick !== 1'b1 && ++n < 20000);
    // new rate must show without finishing the 16384-cycle period
    chk("restart tick", 32'h1, {31'h0, n >= 120 && n <= 132});
    per(128, 3);
    $display("test divisor restart done");
    wr(SBRG_OFF_TXSTAT, 32'h0000_0004);
    wr(SBRG_OFF_DIVISOR, 32'h0000_0000);
    vote(1'b0);
    vote(1'b1);
    $display("test majority vote done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("divisor after reset", SBRG_OFF_DIVISOR, 32'h0000_0000);
    $display("test second reset done");
    tally_and_finish();
  end

  initial begin
    #(4 * 60000);
    errors++;
    $display("MISMATCH watchdog expected end seen hang");
    tally_and_finish();
  end
endmodule : tb_sbrg_top
`default_nettype wire
